// *** core/adcs_regs.svh ***
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH
// Widths of the two user registers
`define ADCS_CFG_W 16
`define ADCS_RES_W 24
// Number of bytes in a full result read
`define ADCS_RD_BYTES 3
// Result field positions
`define ADCS_SIGN_BIT 23
`define ADCS_MSB_BIT 22
`define ADCS_DATA_HI 21
`define ADCS_DATA_LO 6
`define ADCS_ZERO_W 6
// Saturation codes, bits 22..6 as 17-bit two's complement view
`define ADCS_POS_FS 17'h10000
`define ADCS_NEG_FS_M1 17'h0FFFF
// Direction bit values
`define ADCS_DIR_READ 1'b1
`define ADCS_DIR_WRITE 1'b0
`endif

// *** core/adcs_pkg.sv ***
package adcs_pkg;
	// Serial engine states, one-hot
	typedef enum logic [5:0] {
		ADCS_IDLE = 6'h01,
		ADCS_ADDR = 6'h02,
		ADCS_AACK = 6'h04,
		ADCS_WRX = 6'h08,
		ADCS_RTX = 6'h10,
		ADCS_DACK = 6'h20
	} adcs_state_t;
endpackage

// *** core/adcs_if.sv ***
`timescale 1ns/10ps
// Bundle between the serial engine and the pin conditioner
interface adcs_if;
	logic scl; // Synchronised clock level
	logic sda; // Synchronised data level
	logic scl_rise; // One-cycle pulse on clock rise
	logic scl_fall; // One-cycle pulse on clock fall
	logic start; // Start or repeated start seen
	logic stop; // Stop seen
	modport cond (output scl, sda, scl_rise, scl_fall, start, stop);
	modport eng (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// *** core/adcs_pin_cond.sv ***
`timescale 1ns/10ps
// Two-flop synchronisers and edge/condition detection for the bus pins
module adcs_pin_cond (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	adcs_if.cond bus
);
	logic [1:0] scl_meta, sda_meta; // Both stages; bit 0 read only by bit 1
	logic [1:0] next_scl_meta, next_sda_meta;
	logic scl_q, sda_q; // Second stage
	logic scl_d, sda_d; // Delayed copies for edge finding
	logic next_scl_d, next_sda_d;

	// Shift pins through the synchroniser chain
	always_comb begin
		next_scl_meta = {scl_meta[0], scl_in};
		next_sda_meta = {sda_meta[0], sda_in};
		next_scl_d = scl_q;
		next_sda_d = sda_q;
	end

	// Bus idles high, so reset to high to avoid a false condition
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			scl_meta <= 2'h3;
			sda_meta <= 2'h3;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_meta <= next_scl_meta;
			sda_meta <= next_sda_meta;
			scl_d <= next_scl_d;
			sda_d <= next_sda_d;
		end
	end

	assign scl_q = scl_meta[1];
	assign sda_q = sda_meta[1];
	assign bus.scl = scl_q;
	assign bus.sda = sda_q;
	assign bus.scl_rise = scl_q & ~scl_d;
	assign bus.scl_fall = ~scl_q & scl_d;
	assign bus.start = scl_q & scl_d & sda_d & ~sda_q; // [RULE2] [RULE4]
	assign bus.stop = scl_q & scl_d & ~sda_d & sda_q; // [RULE3]
endmodule // adcs_pin_cond

// *** core/adcs_slave.sv ***
`timescale 1ns/10ps
`include "adcs_regs.svh"
// How it works
// RULE1 - Slave only; clock input, data bidirectional
// RULE2 - Start is SDA fall with SCL high
// RULE3 - Stop is SDA rise with SCL high
// RULE4 - Repeated start handled exactly like start
// RULE5 - Eight bits then one acknowledge bit
// RULE6 - Ack pulls low; nak leaves line released
// RULE7 - Data changes only while clock low
// RULE8 - Seven address bits then direction bit
// RULE9 - Selected only on strap address match
// RULE10 - Nak own address while converting
// RULE11 - 16-bit config, 24-bit result registers
// RULE12 - Read up to three bytes; then convert
// RULE13 - Result shifted MSB first on falling edges
// RULE14 - Bit 23 set for zero or positive
// RULE15 - Bits 23,22 flag over and under range
// RULE16 - Bits 21..6 two's complement; low six zero
// RULE17 - Saturate at +FS and -FS minus one
// RULE18 - Zero code may carry either sign
// RULE19 - Sleep after conversion, keep result
// RULE20 - Up to 100 or 400 kbit/s
// RULE21 - Stop after write or short read converts
// RULE22 - Sample incoming data on clock rise
// RULE23 - Address mismatch: release line, ignore until start
module adcs_slave import adcs_pkg::*; #(
	parameter int CFG_W = `ADCS_CFG_W,
	parameter int RES_W = `ADCS_RES_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic scl_in, // Serial clock pin, input only
	input wire logic sda_in, // Serial data pin level
	output logic sda_out, // Always low; the enable does the pulling
	output logic sda_oe, // High while pulling the data line low
	input wire logic [6:0] strap_addr, // Strap-decoded bus address
	input wire logic conv_done, // Converter finished, pulse
	input wire logic conv_positive, // Input zero or above
	input wire logic conv_over, // Input at or above +FS
	input wire logic conv_under, // Input below -FS
	input wire logic [15:0] conv_code, // Bits 21..6 of the result
	output logic conv_start, // Pulse: launch a conversion
	output logic converting, // Conversion in progress
	output logic sleeping, // Idle, result held
	output logic [CFG_W-1:0] channel_and_config, // Last written word
	output logic cfg_valid // Pulse: a new config word landed
);
	adcs_if bus ();

	adcs_state_t state, next_state;
	logic [3:0] bit_cnt, next_bit_cnt; // Bit count within a unit
	logic [7:0] shreg, next_shreg; // Byte being received
	logic [1:0] byte_cnt, next_byte_cnt; // Bytes moved in this transfer
	logic rd_dir, next_rd_dir; // Direction of the current transfer
	logic wrote, next_wrote; // A whole write byte was acked
	logic rd_part, next_rd_part; // Read started but not finished
	logic [RES_W-1:0] conversion_result, next_conversion_result;
	logic [RES_W-1:0] tx_sh, next_tx_sh; // Outgoing shift copy
	logic [CFG_W-1:0] next_channel_and_config;
	logic [CFG_W-1:0] cfg_acc, next_cfg_acc; // Assembly of the two bytes
	logic next_cfg_valid;
	logic next_sda_oe;
	logic next_conv_start, next_converting;
	logic [RES_W-1:0] packed_res; // Formatted result word
	logic [16:0] body; // Bits 22..6

	adcs_pin_cond u_cond (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.bus(bus)
	);

	// Format the converter's outcome into the result word
	always_comb begin
		if (conv_over) begin
			body = `ADCS_POS_FS; // [RULE17] [RULE15]
		end else if (conv_under) begin
			body = `ADCS_NEG_FS_M1; // [RULE17] [RULE15]
		end else begin
			// Inverted MSB marks in-range sign, keeps over/under codes unique
			body = {~conv_positive, conv_code}; // [RULE16]
		end
		// Sign comes straight from the converter, so a zero code
		// may carry either value
		packed_res = {(conv_positive | conv_over) & ~conv_under, // [RULE14] [RULE18]
			body, {`ADCS_ZERO_W{1'b0}}}; // [RULE16]
	end

	// Serial engine and conversion bookkeeping
	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_byte_cnt = byte_cnt;
		next_rd_dir = rd_dir;
		next_wrote = wrote;
		next_rd_part = rd_part;
		next_tx_sh = tx_sh;
		next_cfg_acc = cfg_acc;
		next_channel_and_config = channel_and_config;
		next_cfg_valid = 1'b0;
		next_sda_oe = sda_oe;
		next_conv_start = 1'b0;
		next_converting = converting;
		next_conversion_result = conversion_result;

		// Result is only overwritten when a conversion lands
		if (conv_done && converting) begin
			next_conversion_result = packed_res; // [RULE11]
			next_converting = 1'b0; // [RULE19]
		end

		if (bus.start) begin
			// Start and repeated start both restart address reception
			next_state = ADCS_ADDR; // [RULE2] [RULE4]
			next_bit_cnt = 4'h0;
			next_sda_oe = 1'b0;
			next_byte_cnt = 2'h0;
		end else if (bus.stop) begin
			// Bus free; a finished write or cut-short read launches work
			if ((wrote || rd_part) && !converting) begin
				next_conv_start = 1'b1; // [RULE21]
				next_converting = 1'b1;
			end
			next_wrote = 1'b0;
			next_rd_part = 1'b0;
			next_state = ADCS_IDLE; // [RULE3]
			next_sda_oe = 1'b0;
		end else begin
			unique case (state)
				ADCS_IDLE: begin
					next_sda_oe = 1'b0; // [RULE23]
				end
				ADCS_ADDR: begin
					if (bus.scl_rise) begin
						next_shreg = {shreg[6:0], bus.sda}; // [RULE22] [RULE8]
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (bus.scl_fall && bit_cnt == 4'h8) begin
						// Drive ack only after the falling edge [RULE7]
						if (shreg[7:1] == strap_addr && !converting) begin // [RULE9] [RULE10]
							next_sda_oe = 1'b1; // [RULE6]
							next_rd_dir = (shreg[0] == `ADCS_DIR_READ);
							next_state = ADCS_AACK;
						end else begin
							next_sda_oe = 1'b0; // [RULE6] [RULE23]
							next_state = ADCS_IDLE;
						end
						next_bit_cnt = 4'h0;
					end
				end
				ADCS_AACK: begin
					if (bus.scl_fall) begin
						next_bit_cnt = 4'h0;
						if (rd_dir) begin
							// First data bit replaces the ack [RULE13]
							next_tx_sh = {conversion_result[RES_W-2:0], 1'b0};
							next_sda_oe = ~conversion_result[RES_W-1];
							next_rd_part = 1'b1;
							next_state = ADCS_RTX;
						end else begin
							next_sda_oe = 1'b0; // Release for master data [RULE5]
							next_state = ADCS_WRX;
						end
					end
				end
				ADCS_WRX: begin
					if (bus.scl_rise) begin
						next_shreg = {shreg[6:0], bus.sda}; // [RULE22]
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (bus.scl_fall && bit_cnt == 4'h8) begin
						next_bit_cnt = 4'h0;
						if (byte_cnt < 2'h2) begin
							next_sda_oe = 1'b1; // Ack the byte [RULE5] [RULE6]
							next_cfg_acc = {cfg_acc[7:0], shreg};
							next_byte_cnt = byte_cnt + 2'h1;
							next_wrote = 1'b1;
							next_state = ADCS_DACK;
							if (byte_cnt == 2'h1) begin
								next_channel_and_config = {cfg_acc[7:0], shreg}; // [RULE11]
								next_cfg_valid = 1'b1;
							end
						end else begin
							// Only two bytes fit the config word
							next_sda_oe = 1'b0; // [RULE6]
							next_state = ADCS_IDLE;
						end
					end
				end
				ADCS_RTX: begin
					if (bus.scl_rise) begin
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (bus.scl_fall) begin
						if (bit_cnt == 4'h8) begin
							// Release for the master's ack [RULE5]
							next_sda_oe = 1'b0;
							next_byte_cnt = byte_cnt + 2'h1;
							next_state = ADCS_DACK;
						end else begin
							next_sda_oe = ~tx_sh[RES_W-1]; // [RULE13] [RULE7]
							next_tx_sh = {tx_sh[RES_W-2:0], 1'b0};
						end
					end
				end
				ADCS_DACK: begin
					if (bus.scl_rise && rd_dir) begin
						// Master nak ends the read; sample on rise [RULE22]
						if (bus.sda) begin
							next_state = ADCS_IDLE;
						end
						if (byte_cnt == `ADCS_RD_BYTES) begin
							// All three bytes gone: convert at once [RULE12]
							next_conv_start = 1'b1;
							next_converting = 1'b1;
							next_rd_part = 1'b0;
							next_state = ADCS_IDLE;
						end
					end else if (bus.scl_fall) begin
						next_bit_cnt = 4'h0;
						if (rd_dir) begin
							next_sda_oe = ~tx_sh[RES_W-1]; // [RULE13]
							next_tx_sh = {tx_sh[RES_W-2:0], 1'b0};
							next_state = ADCS_RTX;
						end else begin
							next_sda_oe = 1'b0; // [RULE5]
							next_state = ADCS_WRX;
						end
					end
				end
			endcase
		end
	end

	// Register the engine; a conversion runs after reset, as at power-up
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= ADCS_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			byte_cnt <= 2'h0;
			rd_dir <= 1'b0;
			wrote <= 1'b0;
			rd_part <= 1'b0;
			tx_sh <= 24'h000000;
			cfg_acc <= 16'h0000;
			channel_and_config <= 16'h0000;
			cfg_valid <= 1'b0;
			sda_oe <= 1'b0;
			conv_start <= 1'b1;
			converting <= 1'b1;
			conversion_result <= 24'h000000;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			byte_cnt <= next_byte_cnt;
			rd_dir <= next_rd_dir;
			wrote <= next_wrote;
			rd_part <= next_rd_part;
			tx_sh <= next_tx_sh;
			cfg_acc <= next_cfg_acc;
			channel_and_config <= next_channel_and_config;
			cfg_valid <= next_cfg_valid;
			sda_oe <= next_sda_oe;
			conv_start <= next_conv_start;
			converting <= next_converting;
			conversion_result <= next_conversion_result;
		end
	end

	// Open drain: only ever pull low [RULE1] [RULE20]
	always_ff @(posedge sys_clk) begin
		sda_out <= 1'b0;
		sleeping <= rst_n & ~next_converting; // [RULE19]
	end
endmodule // adcs_slave

// *** sim/adcs_slave_properties.sv ***
`timescale 1ns/10ps
// Port-level checks for the serial result port
module adcs_props #(
	parameter int CFG_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic conv_done,
	input wire logic conv_start,
	input wire logic converting,
	input wire logic sleeping,
	input wire logic [CFG_W-1:0] channel_and_config,
	input wire logic cfg_valid
);
	// One domain, so one clock and one reset for all
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_drive_low; sda_oe |-> sda_out == 1'b0; endproperty
	property p_oe_low; $rose(sda_oe) |-> !scl_in; endproperty
	property p_oe_idle; $rose(sda_oe) |-> !converting; endproperty
	property p_start_busy; conv_start |-> ##[0:1] converting; endproperty
	// Reset itself holds the launch high, so only judge pulses raised out of reset
	property p_start_pulse; $past(rst_n) && conv_start |=> !conv_start; endproperty
	property p_done_sleep; conv_done && converting |=> sleeping && !converting; endproperty
	property p_sleep_excl; sleeping != converting; endproperty
	property p_wake; $fell(sleeping) |-> conv_start || $past(conv_start); endproperty
	property p_cfg_chg; $changed(channel_and_config) |-> cfg_valid; endproperty
	a_drive_low: assert property (p_drive_low) else $error("pin driven high");
	a_oe_low: assert property (p_oe_low) else $error("pull while clock high");
	a_oe_idle: assert property (p_oe_idle) else $error("pull while busy");
	a_start_busy: assert property (p_start_busy) else $error("no busy");
	a_start_pulse: assert property (p_start_pulse) else $error("start too long");
	a_done_sleep: assert property (p_done_sleep) else $error("no sleep");
	a_sleep_excl: assert property (p_sleep_excl) else $error("sleep and busy");
	a_wake: assert property (p_wake) else $error("woke alone");
	a_cfg_chg: assert property (p_cfg_chg) else $error("config moved");
	// Main scenarios reached
	c_start: cover property (conv_start);
	c_cfg: cover property (cfg_valid);
	c_oe: cover property ($rose(sda_oe));
endmodule // adcs_props

bind adcs_slave adcs_props #(.CFG_W(CFG_W)) chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done),
	.conv_start(conv_start), .converting(converting), .sleeping(sleeping),
	.channel_and_config(channel_and_config), .cfg_valid(cfg_valid));

// *** sim/adcs_master.sv ***
`timescale 1ns/10ps
// Bus master model; the clock stands high between frames
module adcs_master (
	output logic scl,
	output logic pull,
	input wire logic sda
);
	localparam realtime Q = 31.25; // Quarter of a 125 ns bit
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	// Start and repeated start: data falls while the clock is high
	task start();
		#Q pull = 1'b0;
		#Q scl = 1'b1;
		#Q pull = 1'b1;
		#Q scl = 1'b0;
	endtask
	// Stop: data rises while the clock is high
	task stop();
		#Q pull = 1'b1;
		#Q scl = 1'b1;
		#Q pull = 1'b0;
		#Q;
	endtask
	// Data moves only in the low phase, sampled mid-high
	task bitx(input logic b, output logic s);
		#Q pull = !b;
		#Q scl = 1'b1;
		#Q s = sda;
		#Q scl = 1'b0;
	endtask
	// Eight bits MSB first, ninth is the acknowledge slot
	task xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic s9);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r[i]);
		end
		bitx(a, s9);
	endtask
endmodule // adcs_master

// *** sim/adcs_slave_bench.sv ***
`timescale 1ns/10ps
module adcs_slave_bench;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic conv_done = 1'b0, conv_positive = 1'b0, conv_over = 1'b0, conv_under = 1'b0;
	logic [15:0] conv_code = 16'h0000;
	logic [6:0] strap_addr = 7'h14; // Static strap level
	logic sda_out, sda_oe, conv_start, converting, sleeping, cfg_valid, cfg_seen = 1'b0;
	logic [15:0] channel_and_config;
	wire scl_line, m_pull, sda_line;
	int num_errors = 0, samples_checked = 0, cycles = 0;
	logic [7:0] rb;
	logic ak;
	logic [23:0] got;
	// Rows: {positive, over, under}, code, expected result word
	logic [42:0] rows [6] = '{{3'h6, 16'h1234, 24'hC00000}, {3'h1, 16'h1234, 24'h3FFFC0},
		{3'h4, 16'h8000, 24'hA00000}, {3'h0, 16'hFFFF, 24'h7FFFC0},
		{3'h4, 16'h0000, 24'h800000}, {3'h0, 16'h0000, 24'h400000}};
	// Pull-up wins unless someone pulls low
	assign sda_line = (sda_oe ? sda_out : 1'b1) & !m_pull;
	adcs_slave dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_line), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .strap_addr(strap_addr), .conv_done(conv_done),
		.conv_positive(conv_positive), .conv_over(conv_over), .conv_under(conv_under),
		.conv_code(conv_code), .conv_start(conv_start), .converting(converting),
		.sleeping(sleeping), .channel_and_config(channel_and_config), .cfg_valid(cfg_valid));
	adcs_master mst_u (.scl(scl_line), .pull(m_pull), .sda(sda_line));
	always #5 sys_clk = ~sys_clk;
	// Hang guard, well above the expected run
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			num_errors++;
			conclude();
		end
		if (cfg_valid === 1'b1) begin
			cfg_seen <= 1'b1;
		end
	end
	task conclude();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [23:0] g, input logic [23:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task chk_bit(input logic g, input logic e);
		chk({23'h0, g}, {23'h0, e});
	endtask
	// Converter finishes; code lines then turn to junk, as they may
	task finish(input logic [42:0] r);
		@(posedge sys_clk);
		{conv_positive, conv_over, conv_under} <= r[42:40];
		conv_code <= r[39:24];
		conv_done <= 1'b1;
		@(posedge sys_clk);
		conv_done <= 1'b0;
		conv_code <= ~r[39:24];
		repeat (2) @(posedge sys_clk);
	endtask
	// Addressed phase with the expected acknowledge
	task addr(input logic rd, input logic e);
		mst_u.xfer({strap_addr, rd}, 1'b1, rb, ak);
		chk_bit(ak, e);
	endtask
	// Read nb bytes, master refuses the last one
	task rd(input int nb, output logic [23:0] v);
		mst_u.start();
		addr(1'b1, 1'b0);
		for (int i = 0; i < nb; i++) begin
			mst_u.xfer(8'hFF, i == nb - 1, rb, ak);
			v = {v[15:0], rb};
		end
		mst_u.stop();
		repeat (4) @(posedge sys_clk);
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk_bit(converting, 1'b1);
		mst_u.start();
		addr(1'b0, 1'b1);
		mst_u.stop();
		for (int i = 0; i < 6; i++) begin
			finish(rows[i]);
			chk_bit(sleeping, 1'b1);
			rd(3, got);
			chk(got, rows[i][23:0]);
			chk_bit(converting, 1'b1);
		end
		finish(rows[4]);
		// Foreign address: refused and ignored
		mst_u.start();
		mst_u.xfer({strap_addr ^ 7'h01, 1'b0}, 1'b1, rb, ak);
		chk_bit(ak, 1'b1);
		mst_u.xfer(8'h00, 1'b1, rb, ak);
		chk_bit(ak, 1'b1);
		mst_u.stop();
		repeat (4) @(posedge sys_clk);
		chk_bit(converting, 1'b0);
		// Two-byte write, third byte refused
		mst_u.start();
		addr(1'b0, 1'b0);
		mst_u.xfer(8'hA5, 1'b1, rb, ak);
		chk_bit(ak, 1'b0);
		mst_u.xfer(8'h3C, 1'b1, rb, ak);
		mst_u.xfer(8'h77, 1'b1, rb, ak);
		chk_bit(ak, 1'b1);
		chk({8'h00, channel_and_config}, 24'h00A53C);
		chk_bit(cfg_seen, 1'b1);
		chk_bit(converting, 1'b0);
		mst_u.stop();
		repeat (4) @(posedge sys_clk);
		chk_bit(converting, 1'b1);
		// Write one byte, repeated start, short read
		finish(rows[2]);
		mst_u.start();
		addr(1'b0, 1'b0);
		mst_u.xfer(8'h12, 1'b1, rb, ak);
		rd(1, got);
		chk(got[7:0], 24'h0000A0);
		chk({8'h00, channel_and_config}, 24'h00A53C);
		chk_bit(converting, 1'b1);
		conclude();
	end
endmodule // adcs_slave_bench
